// file: nfc_host.sv
// Host controller that drives a byte-wide NAND flash over its strobe pins.
// Assumes pin inputs synchronous to clk_sys_i and a pull-up on the ready/busy wire.
`timescale 1ns/1ps
`default_nettype none
module nfc_host (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire nfc_pkg::nfc_req_s req_i,
	output logic done_o,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [7:0] wr_data_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [7:0] rd_data_o,
	output logic ecc_valid_o,
	output var nfc_pkg::nfc_ecc_s ecc_o,
	input wire logic allow_write_i,
	output logic ce_n_o,
	output logic cle_o,
	output logic ale_o,
	output logic we_n_o,
	output logic read_strobe_n_o,
	output logic wp_n_o,
	input wire logic [7:0] bus_lines_i,
	output logic [7:0] bus_lines_o,
	output logic bus_lines_oe_n_o,
	input wire logic rb_i
);
	nfc_pkg::nfc_state_e state, next_state;
	nfc_pkg::nfc_req_s req, next_req;
	logic ph, next_ph;
	logic [2:0] aidx, next_aidx;
	logic [11:0] cnt, next_cnt;
	logic [3:0] wbc, next_wbc;
	logic [7:0] next_bus;
	logic next_oe_n, next_ce_n, next_cle, next_ale, next_we_n, next_wp_n, next_done;
	logic next_read_strobe_n;
	logic buf_in_valid, buf_in_ready;
	logic [7:0] abyte, setup_code, confirm_code;

	nfc_buf #(.W(8), .D(2)) u_rbuf (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.in_valid_i(buf_in_valid),
		.in_ready_o(buf_in_ready),
		.in_data_i(bus_lines_i),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_data_o(rd_data_o)
	);

	assign req_ready_o = (state == nfc_pkg::ST_IDLE);
	assign wr_ready_o = (state == nfc_pkg::ST_WDATA) && !ph;
	assign buf_in_valid = (state == nfc_pkg::ST_RDATA) && ph;

	always_comb begin
		unique case (req.op)
			nfc_pkg::OP_PROG: begin
				setup_code = nfc_pkg::CMD_PROG_SETUP;
				confirm_code = nfc_pkg::CMD_PROG_CONFIRM;
			end
			nfc_pkg::OP_ERASE: begin
				setup_code = nfc_pkg::CMD_ERASE_SETUP;
				confirm_code = nfc_pkg::CMD_ERASE_CONFIRM;
			end
			default: begin
				setup_code = nfc_pkg::CMD_READ_SETUP;
				confirm_code = nfc_pkg::CMD_READ_CONFIRM;
			end
		endcase
	end

	// Column low first, upper nibble of column high and upper six bits of the last row byte forced low
	always_comb begin
		unique case (aidx)
			nfc_pkg::ADDR_COL_LO: abyte = req.col[7:0];
			nfc_pkg::ADDR_COL_HI: abyte = {4'h0, req.col[11:8]};
			nfc_pkg::ADDR_ROW_0: abyte = req.row[7:0];
			nfc_pkg::ADDR_ROW_1: abyte = req.row[15:8];
			default: abyte = {6'h00, req.row[17:16]};
		endcase
	end

	always_comb begin
		next_state = state;
		next_req = req;
		next_ph = ph;
		next_aidx = aidx;
		next_cnt = cnt;
		next_wbc = wbc;
		next_bus = bus_lines_o;
		next_oe_n = bus_lines_oe_n_o;
		next_ce_n = ce_n_o;
		next_cle = cle_o;
		next_ale = ale_o;
		next_we_n = we_n_o;
		next_read_strobe_n = read_strobe_n_o;
		next_wp_n = allow_write_i;
		next_done = 1'b0;
		unique case (state)
			nfc_pkg::ST_IDLE: begin
				next_ce_n = 1'b1;
				next_cle = 1'b0;
				next_ale = 1'b0;
				next_we_n = 1'b1;
				next_read_strobe_n = 1'b1;
				next_oe_n = 1'b1;
				if (req_valid_i) begin
					next_req = req_i;
					next_cnt = req_i.len;
					next_ph = 1'b0;
					next_ce_n = 1'b0;
					next_state = nfc_pkg::ST_CMD1;
				end
			end
			nfc_pkg::ST_CMD1, nfc_pkg::ST_CMD2: begin
				if (!ph) begin
					next_we_n = 1'b0;
					next_cle = 1'b1;
					next_ale = 1'b0;
					next_oe_n = 1'b0;
					next_bus = (state == nfc_pkg::ST_CMD1) ? setup_code : confirm_code;
					next_ph = 1'b1;
				end else begin
					next_we_n = 1'b1;
					next_ph = 1'b0;
					if (state == nfc_pkg::ST_CMD1) begin
						next_state = nfc_pkg::ST_ADDR;
						// Erase skips the column cycles
						next_aidx = (req.op == nfc_pkg::OP_ERASE) ? nfc_pkg::ADDR_ROW_0 :
							nfc_pkg::ADDR_COL_LO;
					end else begin
						next_state = nfc_pkg::ST_WAIT;
						next_wbc = '0;
					end
				end
			end
			nfc_pkg::ST_ADDR: begin
				if (!ph) begin
					next_we_n = 1'b0;
					next_cle = 1'b0;
					next_ale = 1'b1;
					next_oe_n = 1'b0;
					next_bus = abyte;
					next_ph = 1'b1;
				end else begin
					next_we_n = 1'b1;
					next_ph = 1'b0;
					if (aidx == nfc_pkg::ADDR_ROW_2) begin
						next_state = (req.op == nfc_pkg::OP_PROG) ? nfc_pkg::ST_WDATA :
							nfc_pkg::ST_CMD2;
					end else begin
						next_aidx = aidx + 1'b1;
					end
				end
			end
			nfc_pkg::ST_WDATA: begin
				if (!ph) begin
					next_ale = 1'b0;
					if (wr_valid_i) begin
						next_we_n = 1'b0;
						next_bus = wr_data_i;
						next_ph = 1'b1;
					end
				end else begin
					next_we_n = 1'b1;
					next_ph = 1'b0;
					next_cnt = cnt - 1'b1;
					if (cnt == nfc_pkg::LEN_ONE) begin
						next_state = nfc_pkg::ST_CMD2;
					end
				end
			end
			nfc_pkg::ST_WAIT: begin
				next_cle = 1'b0;
				next_oe_n = 1'b1;
				if (wbc != nfc_pkg::WB_CNT) begin
					next_wbc = wbc + 1'b1;
				end else if (rb_i) begin
					next_ph = 1'b0;
					if (req.op == nfc_pkg::OP_READ) begin
						next_state = nfc_pkg::ST_RDATA;
					end else begin
						next_state = nfc_pkg::ST_IDLE;
						next_done = 1'b1;
						next_ce_n = 1'b1;
					end
				end
			end
			nfc_pkg::ST_RDATA: begin
				if (!ph) begin
					// Hold off the strobe until the buffer has room
					if (buf_in_ready) begin
						next_read_strobe_n = 1'b0;
						next_ph = 1'b1;
					end
				end else begin
					next_read_strobe_n = 1'b1;
					next_ph = 1'b0;
					next_cnt = cnt - 1'b1;
					if (cnt == nfc_pkg::LEN_ONE) begin
						next_state = nfc_pkg::ST_IDLE;
						next_done = 1'b1;
						next_ce_n = 1'b1;
					end
				end
			end
			default: begin
				next_state = nfc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state <= nfc_pkg::ST_IDLE;
			req <= '0;
			ph <= 1'b0;
			aidx <= '0;
			cnt <= '0;
			wbc <= '0;
			bus_lines_o <= '0;
			bus_lines_oe_n_o <= 1'b1;
			ce_n_o <= 1'b1;
			cle_o <= 1'b0;
			ale_o <= 1'b0;
			we_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			wp_n_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			state <= next_state;
			req <= next_req;
			ph <= next_ph;
			aidx <= next_aidx;
			cnt <= next_cnt;
			wbc <= next_wbc;
			bus_lines_o <= next_bus;
			bus_lines_oe_n_o <= next_oe_n;
			ce_n_o <= next_ce_n;
			cle_o <= next_cle;
			ale_o <= next_ale;
			we_n_o <= next_we_n;
			read_strobe_n_o <= next_read_strobe_n;
			wp_n_o <= next_wp_n;
			done_o <= next_done;
		end
	end

	// Single-error syndrome over each 528-byte chunk of the stream
	logic feed, last;
	logic [7:0] fb;
	logic [9:0] eidx, next_eidx;
	logic [12:0] chain [9];
	nfc_pkg::nfc_ecc_s acc, next_acc, next_ecc;
	logic next_ecc_valid;
	logic rd_phase;
	assign rd_phase = (state == nfc_pkg::ST_RDATA);
	assign feed = (wr_valid_i && wr_ready_o) || buf_in_valid;
	assign fb = buf_in_valid ? bus_lines_i : wr_data_i;
	assign last = (cnt == nfc_pkg::LEN_ONE) || (eidx == nfc_pkg::ECC_LAST);
	assign chain[0] = acc.syn;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_syn
			assign chain[g+1] = chain[g] ^ (fb[g] ? {eidx, 3'(g)} : 13'h0000);
		end
	endgenerate

	always_comb begin
		next_acc = acc;
		next_eidx = eidx;
		next_ecc = ecc_o;
		next_ecc_valid = 1'b0;
		if (req_valid_i && req_ready_o) begin
			next_acc = '0;
			next_eidx = '0;
		end else if (feed) begin
			next_acc = {chain[8], acc.par ^ (^fb)};
			next_eidx = eidx + 1'b1;
			if (last) begin
				next_ecc = next_acc;
				next_ecc_valid = 1'b1;
				next_acc = '0;
				next_eidx = '0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			acc <= '0;
			eidx <= '0;
			ecc_o <= '0;
			ecc_valid_o <= 1'b0;
		end else begin
			acc <= next_acc;
			eidx <= next_eidx;
			ecc_o <= next_ecc;
			ecc_valid_o <= next_ecc_valid;
		end
	end

	a_cle_cmd_latch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$rose(we_n_o) && cle_o |-> !bus_lines_oe_n_o && !ale_o && $stable(bus_lines_o))
		else $error("command latched without driven bus");
	a_ale_addr_latch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$rose(we_n_o) && ale_o |-> !bus_lines_oe_n_o && !cle_o && $stable(bus_lines_o))
		else $error("address latched without driven bus");
	a_data_strobe_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$fell(we_n_o) |-> !bus_lines_oe_n_o ##1 ($rose(we_n_o) && $stable(bus_lines_o)))
		else $error("write strobe pulse malformed");
	a_col_top_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!we_n_o && ale_o && aidx == nfc_pkg::ADDR_COL_HI |-> bus_lines_o[7:4] == 4'h0)
		else $error("column high byte upper bits not low");
	a_row_top_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!we_n_o && ale_o && aidx == nfc_pkg::ADDR_ROW_2 |-> bus_lines_o[7:2] == 6'h00)
		else $error("last row byte upper bits not low");
	a_erase_rows_only: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		ale_o && req.op == nfc_pkg::OP_ERASE |-> aidx >= nfc_pkg::ADDR_ROW_0)
		else $error("column cycle sent for erase");
	a_confirm_then_wait: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$rose(we_n_o) && cle_o && state == nfc_pkg::ST_WAIT |=> read_strobe_n_o[*4])
		else $error("strobe issued inside busy window");
	a_read_after_ready: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$fell(read_strobe_n_o) |-> $past(rb_i, 1) || $past(rd_phase, 2))
		else $error("read strobe before ready");
	a_wp_follows: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!$past(srst_i) |-> wp_n_o == $past(allow_write_i))
		else $error("write protect does not follow enable");
	a_strobes_apart: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!read_strobe_n_o |-> we_n_o && bus_lines_oe_n_o ##1 read_strobe_n_o)
		else $error("read strobe overlaps drive or lasts too long");
endmodule // nfc_host
`default_nettype wire

// file: nfc_pkg.sv
// Constants, types and request carriers for the NAND flash host controller.
// Assumes one 25 MHz system clock and a device that samples on write-strobe rising edges.
package nfc_pkg;
	localparam int CLK_NS = 40;
	localparam int WB_NS = 100;
	localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] WB_CNT = 4'(WB_CYC);
	localparam int PAGE_BYTES = 2112;
	localparam int ECC_CHUNK = 528;
	localparam logic [9:0] ECC_LAST = 10'(ECC_CHUNK - 1);
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
	localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [2:0] ADDR_COL_LO = 3'h0;
	localparam logic [2:0] ADDR_COL_HI = 3'h1;
	localparam logic [2:0] ADDR_ROW_0 = 3'h2;
	localparam logic [2:0] ADDR_ROW_1 = 3'h3;
	localparam logic [2:0] ADDR_ROW_2 = 3'h4;
	localparam logic [11:0] LEN_ONE = 12'h001;
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_PROG = 2'h1,
		OP_ERASE = 2'h2
	} nfc_op_e;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CMD1 = 7'h02,
		ST_ADDR = 7'h04,
		ST_WDATA = 7'h08,
		ST_CMD2 = 7'h10,
		ST_WAIT = 7'h20,
		ST_RDATA = 7'h40
	} nfc_state_e;
	typedef struct packed {
		nfc_op_e op;
		logic [11:0] col;
		logic [17:0] row;
		logic [11:0] len;
	} nfc_req_s;
	typedef struct packed {
		logic [12:0] syn;
		logic par;
	} nfc_ecc_s;
endpackage

// file: nfc_buf.sv
// Two-entry flip-flop buffer with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module nfc_buf #(
	parameter int W = 8,
	parameter int D = 2
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(D);
	logic [W-1:0] mem [D];
	logic [W-1:0] next_mem [D];
	logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
	logic [CW-1:0] cnt, next_cnt;
	logic push, pop;

	assign in_ready_o = (cnt != CNT_FULL);
	assign out_valid_o = (cnt != '0);
	assign out_data_o = mem[rptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	genvar e;
	generate
		for (e = 0; e < D; e++) begin : g_entry
			assign next_mem[e] = (push && wptr == AW'(e)) ? in_data_i : mem[e];
		end
	endgenerate

	always_comb begin
		next_wptr = wptr;
		next_rptr = rptr;
		next_cnt = cnt;
		if (push) begin
			next_wptr = (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
		end
		if (pop) begin
			next_rptr = (rptr == PTR_LAST) ? '0 : rptr + 1'b1;
		end
		if (push && !pop) begin
			next_cnt = cnt + 1'b1;
		end else if (pop && !push) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wptr <= '0;
			rptr <= '0;
			cnt <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			cnt <= next_cnt;
		end
		mem <= next_mem;
	end
endmodule // nfc_buf
`default_nettype wire

// file: nfc_flash_model.sv
// Behavioural flash device that answers the host controller pins.
// Assumes resolved pin levels; busy times are shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
	parameter int PROG_NS = 2010,
	parameter int ERASE_NS = 4010,
	parameter int READ_NS = 1010,
	parameter int ACC_NS = 15
) (
	input wire logic ce_n_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic we_n_i,
	input wire logic read_strobe_n_i,
	input wire logic wp_n_i,
	input wire logic [7:0] bus_i,
	output logic [7:0] dq_o,
	output logic drive_o,
	output logic rb_low_o,
	output var int viol_o
);
	logic [7:0] mem [int];
	logic [7:0] pend [int];
	logic [15:0] cw = 16'h0000;
	logic [23:0] rw = 24'h000000;
	logic [7:0] cmd = 8'h00;
	int n = 0;
	int q[$];
	realtime t_rd_fall = -100.0;
	initial begin
		dq_o = 8'h00;
		drive_o = 1'b0;
		rb_low_o = 1'b0;
		viol_o = 0;
	end
	function automatic int key();
		return int'({rw[17:0], cw[11:0]});
	endfunction
	// Runs to the end whatever chip select does
	task automatic busy(input int ns);
		rb_low_o = 1'b1;
		#(ns);
		rb_low_o = 1'b0;
	endtask
	always @(negedge we_n_i) if (rb_low_o) viol_o++;
	always @(posedge we_n_i) begin
		if (!ce_n_i && cle_i) begin
			cmd = bus_i;
			n = 0;
			if (bus_i == 8'h80) pend.delete();
			if (bus_i == 8'h30) busy(READ_NS);
			if (bus_i == 8'h10) begin
				if (wp_n_i) foreach (pend[k]) mem[k] = pend[k];
				busy(PROG_NS);
			end
			if (bus_i == 8'hD0) begin
				q.delete();
				foreach (mem[k]) if ((k >> 19) == int'(rw[17:7])) q.push_back(k);
				if (wp_n_i) foreach (q[i]) mem.delete(q[i]);
				busy(ERASE_NS);
			end
		end else if (!ce_n_i && ale_i) begin
			if (cmd == 8'h60) begin
				if (n < 3) rw[n*8 +: 8] = bus_i;
				if ((n == 2 && bus_i[7:2] != 0) || n > 2) viol_o++;
			end else if (n < 2) begin
				cw[n*8 +: 8] = bus_i;
				if (n == 1 && bus_i[7:4] != 0) viol_o++;
			end else if (n < 5) begin
				rw[(n-2)*8 +: 8] = bus_i;
				if (n == 4 && bus_i[7:2] != 0) viol_o++;
			end
			n++;
		end else if (!ce_n_i) begin
			pend[key()] = bus_i;
			cw++;
		end
	end
	always @(negedge read_strobe_n_i) begin
		if (rb_low_o || $realtime - t_rd_fall < 25.0) viol_o++;
		t_rd_fall = $realtime;
		if (!ce_n_i) begin
			#(ACC_NS);
			dq_o = mem.exists(key()) ? mem[key()] : 8'hFF;
			drive_o = 1'b1;
			cw++;
		end
	end
	// Released lines must not keep showing the last byte
	always @(posedge read_strobe_n_i or posedge ce_n_i) begin
		#3;
		drive_o = 1'b0;
		dq_o = ~dq_o;
	end
endmodule // nfc_flash_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench: host controller against a behavioural flash device.
// Assumes the model's shortened busy times and a pull-up on ready/busy.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {
		nfc_pkg::nfc_op_e op;
		logic [11:0] col;
		logic [17:0] row;
		logic [11:0] len;
		logic [7:0] first;
		logic [7:0] step;
	} nfc_case_s;
	logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b1, allow = 1'b1;
	nfc_pkg::nfc_req_s req = '0;
	logic [7:0] wr_data = 8'h00;
	logic req_ready, done, rd_valid, ecc_valid, ce_n, cle, ale, we_n, rd_strobe_n, wp_n;
	logic oe_n, drv, rb_low, wr_ready;
	logic [7:0] rd_data, bus_o, dq, bus_w;
	nfc_pkg::nfc_ecc_s ecc;
	int viol, ecc_n = 0, err_count = 0, checks = 0, cyc = 0;
	wire rb_w = ~rb_low;
	assign bus_w = oe_n ? dq : bus_o;
	always #20 clk = ~clk;
	nfc_host i_nfc_host (.clk_sys_i(clk), .srst_i(srst), .req_valid_i(req_valid),
		.req_ready_o(req_ready), .req_i(req), .done_o(done), .wr_valid_i(wr_valid),
		.wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
		.rd_data_o(rd_data), .ecc_valid_o(ecc_valid), .ecc_o(ecc), .allow_write_i(allow),
		.ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n), .read_strobe_n_o(rd_strobe_n),
		.wp_n_o(wp_n), .bus_lines_i(bus_w), .bus_lines_o(bus_o), .bus_lines_oe_n_o(oe_n),
		.rb_i(rb_w));
	nfc_flash_model i_nfc_flash_model (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
		.read_strobe_n_i(rd_strobe_n), .wp_n_i(wp_n), .bus_i(bus_w), .dq_o(dq),
		.drive_o(drv), .rb_low_o(rb_low), .viol_o(viol));
	nfc_case_s rows [7] = '{
		'{nfc_pkg::OP_PROG, 12'h7FE, 18'h00041, 12'h004, 8'h10, 8'h01},
		'{nfc_pkg::OP_READ, 12'h7FE, 18'h00041, 12'h004, 8'h10, 8'h01},
		'{nfc_pkg::OP_PROG, 12'h000, 18'h3FFFF, 12'h003, 8'hA0, 8'h01},
		'{nfc_pkg::OP_READ, 12'h001, 18'h3FFFF, 12'h002, 8'hA1, 8'h01},
		'{nfc_pkg::OP_ERASE, 12'h000, 18'h00041, 12'h001, 8'h00, 8'h00},
		'{nfc_pkg::OP_READ, 12'h600, 18'h00041, 12'h212, 8'hFF, 8'h00},
		'{nfc_pkg::OP_READ, 12'h000, 18'h3FFFF, 12'h003, 8'hA0, 8'h01}
	};
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Syndrome of the last chunk of a transfer
	function automatic nfc_pkg::nfc_ecc_s ecc_exp(input nfc_case_s c);
		nfc_pkg::nfc_ecc_s e;
		int s;
		logic [7:0] v;
		e = '0;
		s = ((int'(c.len) - 1) / nfc_pkg::ECC_CHUNK) * nfc_pkg::ECC_CHUNK;
		for (int i = s; i < int'(c.len); i++) begin
			v = 8'(c.first + i * c.step);
			for (int b = 0; b < 8; b++) if (v[b]) begin
				e.syn ^= {10'(i - s), 3'(b)};
				e.par ^= 1'b1;
			end
		end
		return e;
	endfunction
	task automatic run_op(input nfc_case_s c, input int stall);
		int k;
		k = 0;
		ecc_n = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req = '{op: c.op, col: c.col, row: c.row, len: c.len};
		while (req_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		rd_ready = (stall == 0);
		fork
			if (c.op == nfc_pkg::OP_PROG) for (int i = 0; i < c.len; i++) begin
				wr_data = 8'(c.first + i * c.step);
				wr_valid = 1'b1;
				while (wr_ready !== 1'b1) @(negedge clk);
				@(negedge clk);
				wr_valid = 1'b0;
				repeat (2) @(negedge clk);
			end
			if (c.op == nfc_pkg::OP_READ) begin
				repeat (stall) @(negedge clk);
				rd_ready = 1'b1;
				while (k < c.len) begin
					if (rd_valid === 1'b1) begin
						chk(rd_data, 8'(c.first + k * c.step));
						k++;
					end
					@(negedge clk);
				end
			end
			begin
				@(negedge clk);
				while (done !== 1'b1) @(negedge clk);
			end
		join
		repeat (2) @(negedge clk);
		chk(ecc_n, c.op == nfc_pkg::OP_ERASE ? 0 :
			(int'(c.len) + nfc_pkg::ECC_CHUNK - 1) / nfc_pkg::ECC_CHUNK);
		if (c.op != nfc_pkg::OP_ERASE) chk(ecc, ecc_exp(c));
	endtask
	always @(negedge clk) begin
		cyc++;
		if (ecc_valid === 1'b1) ecc_n++;
		if (done === 1'b1) chk(rb_w, 1'b1);
		if (drv) chk(oe_n, 1'b1);
		if (cyc == 30000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		foreach (rows[i]) begin
			run_op(rows[i], 0);
			$display("row %0d done", i);
		end
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		chk({ce_n, cle, ale, we_n, rd_strobe_n, wp_n, oe_n, done, rd_valid, ecc_valid, req_ready},
			11'h4D1);
		srst = 1'b0;
		repeat (3) @(negedge clk);
		chk(wp_n, 1'b1);
		$display("reset test done");
		allow = 1'b0;
		repeat (3) @(negedge clk);
		chk(wp_n, 1'b0);
		run_op('{nfc_pkg::OP_PROG, 12'h010, 18'h00100, 12'h002, 8'h77, 8'h01}, 0);
		allow = 1'b1;
		run_op('{nfc_pkg::OP_READ, 12'h010, 18'h00100, 12'h002, 8'hFF, 8'h00}, 0);
		$display("protect test done");
		run_op('{nfc_pkg::OP_PROG, 12'h000, 18'h00200, 12'h006, 8'h30, 8'h03}, 0);
		run_op('{nfc_pkg::OP_READ, 12'h000, 18'h00200, 12'h006, 8'h30, 8'h03}, 40);
		$display("stall test done");
		chk(viol, 0);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
